// File: common/airc_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Fresh sample, placement mode and limits toward the comparator
interface airc_conv_if;
  logic [15:0] sample;
  logic bypass;
  logic [31:0] upperLimit;
  logic [31:0] lowerLimit;
  logic [31:0] placedWord;
  logic hit;

  modport regs (
    output sample,
    output bypass,
    output upperLimit,
    output lowerLimit,
    input placedWord,
    input hit
  );

  modport cmp (
    input sample,
    input bypass,
    input upperLimit,
    input lowerLimit,
    output placedWord,
    output hit
  );
endinterface
`default_nettype wire

// File: common/airc_pkg.sv
// ==========================================================================
// Register map, field layout and reset values
package airc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;

  // ========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_RAW_FLAGS = 8'h10;
  localparam logic [7:0] OFF_RESULT = 8'h14;
  localparam logic [7:0] OFF_CORR_OFFSET = 8'h18;
  localparam logic [7:0] OFF_CONV_STATE = 8'h20;
  localparam logic [7:0] OFF_WIN_UPPER = 8'h24;
  localparam logic [7:0] OFF_WIN_LOWER = 8'h28;

  // ========================================================================
  // Event bit positions, shared by the flag and mask registers
  localparam int BIT_CALIB = 0;
  localparam int BIT_SPARE = 1;
  localparam int BIT_CONV = 2;
  localparam int BIT_WINDOW = 3;
  localparam int EVT_W = 4;

  // Busy bit of the converter state register
  localparam int BIT_BUSY = 1;

  // Half-word positions
  localparam int UPPER_LSB = 16;
  localparam int LOWER_LSB = 0;

  // ========================================================================
  // Reset values
  localparam logic [3:0] RST_IRQ_MASK = 4'hf;
  localparam logic [3:0] RST_RAW_FLAGS = 4'h0;
  localparam logic [31:0] RST_RESULT = 32'h00000000;
  localparam logic [31:0] RST_CORR_OFFSET = 32'h00000000;
  localparam logic [31:0] RST_WIN_UPPER = 32'h0fffffff;
  localparam logic [31:0] RST_WIN_LOWER = 32'h00000000;
  localparam logic RST_BUSY = 1'b0;
  localparam logic [31:0] READ_IDLE = 32'h00000000;

endpackage

// File: src/airc_regs.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module airc_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic calibDone,
  input wire logic convDone,
  input wire logic [15:0] convData,
  input wire logic convBusy,
  input wire logic filterBypass,
  input wire logic comparatorOn,
  output logic [15:0] correctionOffset,
  output logic irq
);

  // ========================================================================
  // Declarations
  logic [3:0] maskReg;
  logic [3:0] maskNext;
  logic [3:0] flagsReg;
  logic [3:0] flagsNext;
  logic [31:0] resultReg;
  logic [31:0] offsetReg;
  logic [31:0] upperReg;
  logic [31:0] lowerReg;
  logic busyReg;
  logic [31:0] rdataReg;
  logic [31:0] rdataNext;
  logic [15:0] corrReg;
  logic irqReg;
  logic wrMask;
  logic wrOffset;
  logic wrUpper;
  logic wrLower;
  logic rdFlags;
  logic [3:0] flagSet;
  logic [3:0] flagClr;
  logic [3:0] pending;

  airc_conv_if conv ();

  // ========================================================================
  // Decode helpers
  function automatic logic hitsAddr(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return addr == target;
  endfunction

  function automatic logic [15:0] pickHalf(
    input logic [31:0] word,
    input logic lower
  );
    logic [15:0] half;
    half = 16'h0000;
    if (lower) begin
      half = word[airc_pkg::LOWER_LSB +: airc_pkg::HALF_W];
    end else begin
      half = word[airc_pkg::UPPER_LSB +: airc_pkg::HALF_W];
    end
    return half;
  endfunction

  always_comb begin
    wrMask = regWrite && hitsAddr(regAddr, airc_pkg::OFF_IRQ_MASK);
    wrOffset = regWrite && hitsAddr(regAddr, airc_pkg::OFF_CORR_OFFSET);
    wrUpper = regWrite && hitsAddr(regAddr, airc_pkg::OFF_WIN_UPPER);
    wrLower = regWrite && hitsAddr(regAddr, airc_pkg::OFF_WIN_LOWER);
    rdFlags = regRead && hitsAddr(regAddr, airc_pkg::OFF_RAW_FLAGS);
  end

  // ========================================================================
  // Comparator and placement
  always_comb begin
    conv.sample = convData;
    conv.bypass = filterBypass;
    conv.upperLimit = upperReg;
    conv.lowerLimit = lowerReg;
  end

  airc_result_compare compare (
    .conv(conv.cmp)
  );

  // ========================================================================
  // Interrupt mask
  always_comb begin
    maskNext = maskReg;
    if (wrMask) begin
      maskNext = regWdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      maskReg <= airc_pkg::RST_IRQ_MASK;
    end else begin
      maskReg <= maskNext;
    end
  end

  // ========================================================================
  // Raw event flags
  // A set arriving in the same cycle as the clearing read wins, so no
  // event is lost; the read itself still returns the pre-clear value.
  always_comb begin
    flagSet = 4'h0;
    flagClr = 4'h0;
    if (rdFlags) begin
      flagClr[airc_pkg::BIT_CALIB] = 1'b1;
      flagClr[airc_pkg::BIT_CONV] = 1'b1;
      flagClr[airc_pkg::BIT_WINDOW] = 1'b1;
    end
    flagSet[airc_pkg::BIT_CALIB] = calibDone;
    flagSet[airc_pkg::BIT_CONV] = convDone;
    if (convDone && comparatorOn) begin
      flagSet[airc_pkg::BIT_WINDOW] = conv.hit;
      // A fresh miss drops the flag even without a read
      flagClr[airc_pkg::BIT_WINDOW] = !conv.hit;
    end
    flagsNext = (flagsReg & ~flagClr) | flagSet;
    flagsNext[airc_pkg::BIT_SPARE] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flagsReg <= airc_pkg::RST_RAW_FLAGS;
    end else begin
      flagsReg <= flagsNext;
    end
  end

  // ========================================================================
  // Conversion result, hardware written only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resultReg <= airc_pkg::RST_RESULT;
    end else if (convDone) begin
      resultReg <= conv.placedWord;
    end
  end

  // ========================================================================
  // Correction offset
  // The half in use follows the live bypass setting; changing bypass
  // without recalibrating leaves a stale half selected.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      offsetReg <= airc_pkg::RST_CORR_OFFSET;
    end else if (wrOffset) begin
      offsetReg <= regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      corrReg <= 16'h0000;
    end else begin
      corrReg <= pickHalf(offsetReg, filterBypass);
    end
  end

  // ========================================================================
  // Converter state
  // Busy mirrors the converter; software writes cannot fake it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busyReg <= airc_pkg::RST_BUSY;
    end else begin
      busyReg <= convBusy;
    end
  end

  // ========================================================================
  // Window limits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upperReg <= airc_pkg::RST_WIN_UPPER;
    end else if (wrUpper) begin
      upperReg <= regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lowerReg <= airc_pkg::RST_WIN_LOWER;
    end else if (wrLower) begin
      lowerReg <= regWdata;
    end
  end

  // ========================================================================
  // Interrupt
  always_comb begin
    pending = flagsNext & ~maskNext;
    pending[airc_pkg::BIT_SPARE] = 1'b0;
  end

  // Built from next values so the line follows the flags cycle for cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqReg <= 1'b0;
    end else begin
      irqReg <= |pending;
    end
  end

  // ========================================================================
  // Read path, data valid in the cycle after the strobe
  always_comb begin
    rdataNext = airc_pkg::READ_IDLE;
    if (regRead) begin
      case (regAddr)
        airc_pkg::OFF_IRQ_MASK: begin
          rdataNext[3:0] = maskReg;
        end
        airc_pkg::OFF_RAW_FLAGS: begin
          rdataNext[3:0] = flagsReg;
        end
        airc_pkg::OFF_RESULT: begin
          rdataNext = resultReg;
        end
        airc_pkg::OFF_CORR_OFFSET: begin
          rdataNext = offsetReg;
        end
        airc_pkg::OFF_CONV_STATE: begin
          rdataNext[airc_pkg::BIT_BUSY] = busyReg;
        end
        airc_pkg::OFF_WIN_UPPER: begin
          rdataNext = upperReg;
        end
        airc_pkg::OFF_WIN_LOWER: begin
          rdataNext = lowerReg;
        end
        default: begin
          rdataNext = airc_pkg::READ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdataReg <= airc_pkg::READ_IDLE;
    end else begin
      rdataReg <= rdataNext;
    end
  end

  // ========================================================================
  // Outputs
  always_comb begin
    regRdata = rdataReg;
    correctionOffset = corrReg;
    irq = irqReg;
  end

endmodule
`default_nettype wire

// File: src/airc_result_compare.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Places a sample in its half-word and checks it against the window
module airc_result_compare (
  airc_conv_if.cmp conv
);

  // ========================================================================
  // Placement
  function automatic logic [31:0] placeSample(
    input logic [15:0] value,
    input logic toLower
  );
    logic [31:0] word;
    word = 32'h00000000;
    if (toLower) begin
      word[airc_pkg::LOWER_LSB +: airc_pkg::HALF_W] = value;
    end else begin
      word[airc_pkg::UPPER_LSB +: airc_pkg::HALF_W] = value;
    end
    return word;
  endfunction

  always_comb begin
    conv.placedWord = placeSample(conv.sample, conv.bypass);
  end

  // ========================================================================
  // Window, inclusive at both limits; the unused half is zero so the
  // compare sees the same word that software reads back
  always_comb begin
    conv.hit = (conv.placedWord >= conv.lowerLimit) &&
               (conv.placedWord <= conv.upperLimit);
  end

endmodule
`default_nettype wire

// File: testbench/airc_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Port-level checks of the register block
module airc_regs_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic calibDone,
  input wire logic convDone,
  input wire logic [15:0] convData,
  input wire logic convBusy,
  input wire logic filterBypass,
  input wire logic comparatorOn,
  input wire logic [15:0] correctionOffset,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence flagRead;
    regRead && regAddr == 8'h10;
  endsequence
  // Events at the read edge survive the clear, so exclude them
  sequence quietRead;
    regRead && regAddr == 8'h10 && !calibDone && !convDone;
  endsequence
  sequence resRead;
    regRead && regAddr == 8'h14 && !convDone;
  endsequence

  a_cal_flag: assert property (
    calibDone ##1 flagRead |=> regRdata[0]) else $error("calib flag lost");
  a_conv_flag: assert property (
    convDone ##1 flagRead |=> regRdata[2]) else $error("conv flag lost");
  a_read_clears: assert property (
    quietRead ##1 quietRead |=> regRdata[3:0] == 4'h0)
    else $error("flags not cleared by read");
  a_flag_spares: assert property (
    flagRead |=> regRdata[31:4] == 28'h0 && !regRdata[1])
    else $error("reserved flag bits set");
  a_result_upper: assert property (
    convDone && !filterBypass ##1 resRead
    |=> regRdata == {$past(convData, 2), 16'h0})
    else $error("upper result placement wrong");
  a_result_lower: assert property (
    convDone && filterBypass ##1 resRead
    |=> regRdata == {16'h0, $past(convData, 2)})
    else $error("lower result placement wrong");
  a_rdata_idle: assert property (
    !regRead |=> regRdata == 32'h0) else $error("read data not idle");
  a_busy_state: assert property (
    regRead && regAddr == 8'h20 && $past(rst_n)
    |=> regRdata == {30'h0, $past(convBusy, 2), 1'b0})
    else $error("busy bit wrong");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(calibDone || convDone || regWrite))
    else $error("irq rose without cause");
  a_irq_release: assert property (
    $fell(irq) |-> $past(regWrite || convDone || regRead && regAddr == 8'h10))
    else $error("irq fell without cause");
endmodule
`default_nettype wire

bind airc_regs airc_regs_asserts airc_regs_asserts_inst (.clk(clk),
  .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .calibDone(calibDone), .convDone(convDone), .convData(convData),
  .convBusy(convBusy), .filterBypass(filterBypass),
  .comparatorOn(comparatorOn), .correctionOffset(correctionOffset),
  .irq(irq));

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0;
  logic rst_n = 0;
  logic [7:0] regAddr = 0;
  logic [31:0] regWdata = 0;
  logic regWrite = 0, regRead = 0, calibDone = 0, convDone = 0;
  logic [15:0] convData = 0;
  logic convBusy = 0, filterBypass = 0, comparatorOn = 0, irqSeen;
  logic [31:0] regRdata;
  logic [15:0] correctionOffset;
  logic irq;
  int miscompares = 0, nTests = 0;
  logic [7:0] ra [8] = '{8'h0c, 8'h10, 8'h14, 8'h18,
                         8'h20, 8'h24, 8'h28, 8'h04};
  logic [31:0] rv [8] = '{32'hf, 0, 0, 0, 0, 32'h0fffffff, 0, 0};
  logic [15:0] wd [4] = '{16'h1000, 16'h2000, 16'h2001, 16'h0fff};
  logic wh [4] = '{1, 1, 0, 0};

  airc_regs airc_regs_inst (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .calibDone(calibDone), .convDone(convDone),
    .convData(convData), .convBusy(convBusy), .filterBypass(filterBypass),
    .comparatorOn(comparatorOn), .correctionOffset(correctionOffset),
    .irq(irq));

  always #5 clk = ~clk;

  // ====
  // Bus and event tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string n);
    nTests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // Twice keeps the strobe up for a back-to-back second read
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input bit twice);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    if (!twice) regRead <= 1'b0;
    #1 chk(regRdata, e, "read");
    if (twice) begin
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(regRdata, 32'h0, "reread");
    end
  endtask

  // Event pulse, then a read strobed in the very next cycle
  task automatic ev(input logic c, input logic v, input logic [15:0] d,
                    input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    calibDone <= c;
    convDone <= v;
    convData <= d;
    @(posedge clk);
    calibDone <= 1'b0;
    convDone <= 1'b0;
    regAddr <= a;
    regRead <= 1'b1;
    #1 irqSeen = irq;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regRdata, e, "event read");
  endtask

  task automatic conclude;
    $display("miscompares=%0d nTests=%0d", miscompares, nTests);
    if (miscompares == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ====
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], rv[i], 0);
    end
    wr(8'h0c, 32'h2);
    rd(8'h0c, 32'h2, 0);
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'h0, 0);
    wr(8'h20, 32'h2);
    rd(8'h20, 32'h0, 0);
    wr(8'h24, 32'h20000000);
    wr(8'h28, 32'h10000000);
    rd(8'h24, 32'h20000000, 0);
    rd(8'h28, 32'h10000000, 0);
    wr(8'h18, 32'h1234abcd);
    rd(8'h18, 32'h1234abcd, 0);
    repeat (2) @(posedge clk);
    #1 chk(correctionOffset, 16'h1234, "offset");
    @(posedge clk);
    filterBypass <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(correctionOffset, 16'habcd, "offset");
    wr(8'h0c, 32'hf);
    // Bypass just changed, so a calibration comes before any conversion
    ev(1, 0, 0, 8'h10, 32'h1);
    chk(irqSeen, 0, "masked irq");
    ev(0, 1, 16'h8001, 8'h14, 32'h00008001);
    rd(8'h10, 32'h4, 1);
    @(posedge clk);
    filterBypass <= 1'b0;
    ev(1, 1, 16'h1234, 8'h14, 32'h12340000);
    rd(8'h10, 32'h5, 1);
    for (int i = 0; i < 3; i += 2) begin
      wr(8'h0c, 32'hf ^ (32'h1 << i));
      ev(i == 0, i == 2, 0, 8'h10, 32'h1 << i);
      chk(irqSeen, 1, "irq");
      chk(irq, 0, "irq after read");
    end
    @(posedge clk);
    comparatorOn <= 1'b1;
    wr(8'h0c, 32'h7);
    // Early results here are only judged by the window, never read back
    for (int i = 0; i < 4; i++) begin
      ev(0, 1, wd[i], 8'h10, wh[i] ? 32'hc : 32'h4);
      chk(irqSeen, wh[i], "window irq");
    end
    ev(0, 1, 16'h1800, 8'h14, 32'h18000000);
    ev(0, 1, 16'h3000, 8'h10, 32'h4);
    ev(0, 1, 16'h1800, 8'h14, 32'h18000000);
    @(posedge clk);
    comparatorOn <= 1'b0;
    ev(0, 1, 16'h3000, 8'h10, 32'hc);
    @(posedge clk);
    convBusy <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h20, 32'h2, 0);
    @(posedge clk);
    convBusy <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h20, 32'h0, 0);
    conclude();
  end

  // The sequence needs about 120 cycles; this leaves wide margin
  initial begin
    #100us;
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
